// *** logic/vsm_sync_mod.v ***
`timescale 1ns/10ps
`include "vsm_map.vh"
module vsm_sync_mod (
    input  wire        CLK_SYS_I,
    input  wire        RST_I,
    input  wire        HORIZ_SYNC_IN_I,
    input  wire        VERT_SYNC_IN_I,
    input  wire        DOUBLE_FREQ_REMOVAL_I,
    input  wire        MASK_MODE_SEL_I,
    input  wire [7:0]  MASK_OFFSET_REG_I,
    input  wire        FALL_MOD_I,
    input  wire        RESYNC_I,
    input  wire [7:0]  COMPARE_CONST_B_I,
    input  wire [7:0]  PULSE_CONST_A_I,
    input  wire [3:0]  OUTPUT_SEL_I,
    input  wire        ALT_ADD_MODE_SEL_I,
    input  wire [15:0] RISE_ADD_VALUE_I,
    input  wire [15:0] FALL_ADD_VALUE_I,
    input  wire [7:0]  LINE_CONST_A_I,
    input  wire [7:0]  LINE_CONST_B_I,
    output reg         HORIZ_SYNC_OUT_SEL_O,
    output reg         VERT_SYNC_OUT_SEL_O,
    output reg         GEN_HORIZ_SYNC_O,
    output reg         GEN_VERT_SYNC_O,
    output reg         CLAMP_PULSE_FOUR_O,
    output reg         PULSE_TIMER_OUT_O,
    output reg  [15:0] CAPTURE_D_REG_O,
    output reg  [7:0]  PULSE_COUNT_O
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Both sync pins come from other timing domains. Each passes
    // three flip-flops; a level counts only once stages two and
    // three agree, so a glitch shorter than a clock is never taken.
    wire [1:0] pin_in;
    wire [1:0] rise_w;
    wire [1:0] fall_w;
    wire       hs_rise;
    wire       hs_fall;
    wire       vs_rise;
    wire       vs_fall;
    genvar     gi;

    // Stages two and three hold the same value
    function pair_agree;
        input [2:0] stages;
        begin
            pair_agree = (stages[1] == stages[2]);
        end
    endfunction

    // Accepted level moves towards the wanted polarity
    function edge_hit;
        input [2:0] stages;
        input       level;
        input       polarity;
        begin
            edge_hit = pair_agree(stages) && (stages[2] == polarity) && (level != polarity);
        end
    endfunction

    // Channel 0 carries horizontal sync, channel 1 vertical sync
    assign pin_in = {VERT_SYNC_IN_I, HORIZ_SYNC_IN_I};

    // One synchroniser and accepted level per channel
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            reg [2:0] stage_q;
            reg       level_q;

            // Shift the pin in; accept the level when stages agree
            always @(posedge CLK_SYS_I or posedge RST_I) begin
                if (RST_I) begin
                    stage_q <= 3'h0;
                    level_q <= 1'b0;
                end else begin
                    stage_q <= {stage_q[1:0], pin_in[gi]};
                    if (pair_agree(stage_q)) level_q <= stage_q[2];
                end
            end

            assign rise_w[gi] = edge_hit(stage_q, level_q, 1'b1);
            assign fall_w[gi] = edge_hit(stage_q, level_q, 1'b0);
        end
    endgenerate

    // Named events used by the rest of the block
    assign hs_rise = rise_w[0];
    assign hs_fall = fall_w[0];
    assign vs_rise = rise_w[1];
    assign vs_fall = fall_w[1];

    // ------------------------------------------------------------
    // Free counter, prescaled
    // ------------------------------------------------------------
    // Both prescalers run from reset and are never cleared, so the
    // free counter tick and the line tick keep a fixed phase. The
    // line and vertical generation timers rely on that phase.
    reg  [3:0]  pre_q;
    reg  [15:0] frc_q;
    wire        frc_tick;
    reg  [1:0]  line_pre_q;
    wire        line_tick;

    assign frc_tick  = (pre_q == (`VSM_FRC_DIV - 4'h1));
    assign line_tick = ({2'h0, line_pre_q} == (`VSM_LINE_DIV - 4'h1));

    // Counter advances on clock/8, never cleared
    always @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            pre_q      <= 4'h0;
            frc_q      <= `VSM_FRC_RST;
            line_pre_q <= 2'h0;
        end else begin
            pre_q      <= frc_tick ? 4'h0 : pre_q + 4'h1;
            if (frc_tick) frc_q <= frc_q + 16'h0001;
            line_pre_q <= line_pre_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Capture D with double-frequency mask
    // ------------------------------------------------------------
    // The free counter holds each value for several clocks, so the
    // compares below stay true for that long; the end compare wins
    // so a mask never outlives its upper bound.
    // An offset of zero makes both bounds equal, so the end compare wins and no mask opens.
    reg  [15:0] mask_lo_q;
    reg  [15:0] mask_hi_q;
    reg         masking_q;
    reg         hout_q;
    wire        mask_on;
    wire        hs_rise_ok;
    wire        hs_fall_ok;

    assign mask_on    = DOUBLE_FREQ_REMOVAL_I && MASK_MODE_SEL_I && masking_q;
    assign hs_rise_ok = hs_rise && !mask_on;
    assign hs_fall_ok = hs_fall && !mask_on;

    // Capture on rise, open mask between offset and twice offset
    always @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            CAPTURE_D_REG_O <= 16'h0000;
            mask_lo_q       <= 16'h0000;
            mask_hi_q       <= 16'h0000;
            masking_q       <= 1'b0;
            hout_q          <= 1'b0;
        end else begin
            if (hs_rise_ok) begin
                CAPTURE_D_REG_O <= frc_q;
                mask_lo_q <= frc_q + {8'h00, MASK_OFFSET_REG_I};
                mask_hi_q <= frc_q + {7'h00, MASK_OFFSET_REG_I, 1'b0};
            end
            if (frc_q == mask_hi_q) masking_q <= 1'b0;
            else if (frc_q == mask_lo_q && !hs_rise_ok) masking_q <= 1'b1;
            if (hs_rise_ok) hout_q <= 1'b1;
            else if (hs_fall_ok) hout_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pulse-count timer and vertical fall modification
    // ------------------------------------------------------------
    // Only unmasked horizontal rises are counted, so a doubled pulse
    // inside a mask interval never advances the fall position.
    // A vertical rise drops any fall still waiting for alignment.
    reg  vout_q;
    reg  fall_pend_q;
    wire cmp_b_hit;
    wire cmp_a_hit;
    wire v_clear;

    assign cmp_b_hit = hs_rise_ok && (PULSE_COUNT_O == COMPARE_CONST_B_I);
    assign cmp_a_hit = hs_rise_ok && (PULSE_COUNT_O == PULSE_CONST_A_I);
    assign v_clear   = FALL_MOD_I ? cmp_b_hit : vs_fall;

    // Count horizontal rises, clear on inverted vertical rise
    always @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            PULSE_COUNT_O     <= 8'h00;
            PULSE_TIMER_OUT_O <= 1'b0;
            vout_q            <= 1'b0;
            fall_pend_q       <= 1'b0;
        end else begin
            if (vs_fall) PULSE_COUNT_O <= 8'h00;
            else if (hs_rise_ok) PULSE_COUNT_O <= PULSE_COUNT_O + 8'h01;
            if (OUTPUT_SEL_I == `VSM_OS_TOGGLE_A) begin
                if (cmp_a_hit) PULSE_TIMER_OUT_O <= !PULSE_TIMER_OUT_O;
            end else if (OUTPUT_SEL_I == `VSM_OS_SETB_CLRA) begin
                if (cmp_b_hit) PULSE_TIMER_OUT_O <= 1'b1;
                else if (cmp_a_hit) PULSE_TIMER_OUT_O <= 1'b0;
            end
            if (vs_rise) begin
                vout_q      <= 1'b1;
                fall_pend_q <= 1'b0;
            end else if (v_clear) begin
                if (RESYNC_I) fall_pend_q <= 1'b1;
                else vout_q <= 1'b0;
            end else if (fall_pend_q && hs_rise_ok) begin
                vout_q      <= 1'b0;
                fall_pend_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Internal vertical generation by alternating adds
    // ------------------------------------------------------------
    // The compare is only looked at on a counter tick, so each value
    // matches once even though the counter holds it for eight clocks.
    // The sum wraps with the counter, keeping the period exact.
    reg  [15:0] ocr_a_q;
    reg         add_fall_next_q;
    reg         gv_q;
    reg         gv_d1_q;
    wire        ocr_hit;

    assign ocr_hit = frc_tick && ALT_ADD_MODE_SEL_I && (frc_q == ocr_a_q);

    // Rise value adds low time, fall value adds high time
    always @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            ocr_a_q         <= 16'h0000;
            add_fall_next_q <= 1'b0;
            gv_q            <= 1'b0;
            gv_d1_q         <= 1'b0;
        end else begin
            gv_d1_q <= gv_q;
            if (ocr_hit) begin
                if (add_fall_next_q) begin
                    ocr_a_q <= ocr_a_q + FALL_ADD_VALUE_I;
                    gv_q    <= 1'b1;
                end else begin
                    ocr_a_q <= ocr_a_q + RISE_ADD_VALUE_I;
                    gv_q    <= 1'b0;
                end
                add_fall_next_q <= !add_fall_next_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Line generation timer and clamp
    // ------------------------------------------------------------
    // A vertical restart does not wait for a line tick, so the first
    // line after it may be up to one tick short; the line period has
    // to divide the frame period for later lines to stay aligned.
    // The clamp starts from the registered horizontal output.
    reg  [7:0] line_cnt_q;
    reg        gh_q;
    reg  [3:0] clamp_q;
    wire       gv_rise;
    wire       line_a;

    assign gv_rise = gv_q && !gv_d1_q;
    assign line_a  = line_tick && (line_cnt_q == LINE_CONST_A_I);

    // Clear on A or vertical rise sets output; B clears output
    always @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            line_cnt_q <= `VSM_LINE_RST;
            gh_q       <= 1'b0;
            clamp_q    <= 4'h0;
        end else begin
            if (line_a || gv_rise) begin
                line_cnt_q <= `VSM_LINE_RST;
                gh_q       <= 1'b1;
            end else if (line_tick) begin
                line_cnt_q <= line_cnt_q + 8'h01;
                if (line_cnt_q == LINE_CONST_B_I) gh_q <= 1'b0;
            end
            if (GEN_HORIZ_SYNC_O && !gh_q) clamp_q <= `VSM_CLAMP_CYC;
            else if (clamp_q != 4'h0) clamp_q <= clamp_q - 4'h1;
        end
    end

    // The four sync outputs and the clamp leave from a flip-flop, one clock after the
    // internal level, so these five share the same delay.
    // The clamp is started from the fall of gh_q while the output is still high, so it rises as the output falls.
    // Registered outputs; selections are static inputs
    always @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            HORIZ_SYNC_OUT_SEL_O <= 1'b0;
            VERT_SYNC_OUT_SEL_O  <= 1'b0;
            GEN_HORIZ_SYNC_O     <= 1'b0;
            GEN_VERT_SYNC_O      <= 1'b0;
            CLAMP_PULSE_FOUR_O   <= 1'b0;
        end else begin
            HORIZ_SYNC_OUT_SEL_O <= hout_q;
            VERT_SYNC_OUT_SEL_O  <= vout_q;
            GEN_HORIZ_SYNC_O     <= gh_q;
            GEN_VERT_SYNC_O      <= gv_q;
            CLAMP_PULSE_FOUR_O   <= (GEN_HORIZ_SYNC_O && !gh_q) || (clamp_q > 4'h1);
        end
    end

endmodule // vsm_sync_mod

// *** logic/vsm_map.vh ***
// Operation
// - Mask matches at capture plus offset, twice
// - Capture free counter on horizontal rise
// - Plain horizontal follows input edges
// - Mask ignores edges and captures
// - Mask mode bit enables offset mode
// - Free counter runs at clock/8, no clear
// - Pulse timer counts rises, clears on vertical fall
// - Vertical cleared by compare B when modified
// - Optional vertical fall aligned to horizontal rise
// - Compare B match at count plus one
// - Output select 0011 toggles, 1001 set/clear
// - Compare A alternately adds rise/fall values
// - Generated vertical set after rise add
// - Alternating add mode bit enables generation
// - Line timer clears on A, B clears output
// - Generated vertical rise restarts line timer
// - Clamp rises after horizontal fall, 6 clocks
`ifndef VSM_MAP_VH
`define VSM_MAP_VH
`define VSM_FRC_DIV      4'h8
`define VSM_LINE_DIV     4'h4
`define VSM_CLAMP_CYC    4'h6
`define VSM_OS_TOGGLE_A  4'h3
`define VSM_OS_SETB_CLRA 4'h9
`define VSM_FRC_RST      16'h0000
`define VSM_LINE_RST     8'h00
`endif

// *** dv/vsm_sync_mod_monitor.sv ***
`timescale 1ns/10ps
// --------------------------------
// Sync block checker
// --------------------------------
module vsm_mon (
    input wire logic        CLK_SYS_I, RST_I, HORIZ_SYNC_IN_I, VERT_SYNC_IN_I, DOUBLE_FREQ_REMOVAL_I,
    input wire logic        FALL_MOD_I, RESYNC_I, HORIZ_SYNC_OUT_SEL_O, VERT_SYNC_OUT_SEL_O,
    input wire logic        GEN_HORIZ_SYNC_O, GEN_VERT_SYNC_O, CLAMP_PULSE_FOUR_O,
    input wire logic [15:0] CAPTURE_D_REG_O,
    input wire logic [7:0]  PULSE_COUNT_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    // Plain horizontal path and capture timing
    property p_hrise; $rose(HORIZ_SYNC_IN_I) && !DOUBLE_FREQ_REMOVAL_I |-> ##[3:6] HORIZ_SYNC_OUT_SEL_O; endproperty
    a_hrise: assert property (p_hrise) else $error("horizontal rise not passed");
    property p_cap; $changed(CAPTURE_D_REG_O) |-> ##[0:1] $rose(HORIZ_SYNC_OUT_SEL_O); endproperty
    a_cap: assert property (p_cap) else $error("capture without horizontal rise");
    // Vertical path and pulse counter clearing
    property p_vset; $rose(VERT_SYNC_IN_I) |-> ##[3:6] VERT_SYNC_OUT_SEL_O; endproperty
    a_vset: assert property (p_vset) else $error("vertical rise not passed");
    property p_vplain; $fell(VERT_SYNC_IN_I) && !FALL_MOD_I && !RESYNC_I |-> ##[3:6] !VERT_SYNC_OUT_SEL_O; endproperty
    a_vplain: assert property (p_vplain) else $error("vertical fall not passed");
    property p_pclr; $fell(VERT_SYNC_IN_I) |-> ##[3:6] (PULSE_COUNT_O == 8'h00); endproperty
    a_pclr: assert property (p_pclr) else $error("pulse counter not cleared");
    // Generated sync and clamp
    property p_genh; $rose(GEN_VERT_SYNC_O) |-> ##[0:4] GEN_HORIZ_SYNC_O; endproperty
    a_genh: assert property (p_genh) else $error("line timer not restarted");
    property p_crise; $fell(GEN_HORIZ_SYNC_O) |-> ##[0:1] $rose(CLAMP_PULSE_FOUR_O); endproperty
    a_crise: assert property (p_crise) else $error("clamp late");
    property p_cwid; $rose(CLAMP_PULSE_FOUR_O) |-> CLAMP_PULSE_FOUR_O [*6] ##1 !CLAMP_PULSE_FOUR_O; endproperty
    a_cwid: assert property (p_cwid) else $error("clamp width wrong");
    c_mask: cover property ($rose(HORIZ_SYNC_OUT_SEL_O) && DOUBLE_FREQ_REMOVAL_I);
    c_fmod: cover property ($fell(VERT_SYNC_OUT_SEL_O) && FALL_MOD_I);
    c_genv: cover property ($rose(GEN_VERT_SYNC_O));
endmodule // vsm_mon
bind vsm_sync_mod vsm_mon u_mon (.*);

// *** dv/vsm_src.sv ***
`timescale 1ns/10ps
// --------------------------------
// Video sync source model
// --------------------------------
module vsm_src #(parameter int LINE = 96, HI = 12, VLINES = 10, VHI = 2) (
    input  wire logic clk_i, rst_i, dbl_i,
    output logic      hs_o, vs_o
);
    int c, l;
    // Line and frame counters; vertical edges sit a quarter into the line
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            c <= 0;
            l <= 0;
            hs_o <= 1'b0;
            vs_o <= 1'b0;
        end else begin
            c <= (c == LINE - 1) ? 0 : c + 1;
            if (c == LINE - 1) l <= (l == VLINES - 1) ? 0 : l + 1;
            hs_o <= (c < HI) || (dbl_i && c >= LINE / 2 - 8 && c < LINE / 2);
            if (c == LINE / 4) vs_o <= (l < VHI);
        end
    end
endmodule // vsm_src

// *** dv/testbench.sv ***
`timescale 1ns/10ps
// --------------------------------
// Sync block testbench
// --------------------------------
module testbench;
    logic        CLK_SYS_I = 1'b0, RST_I = 1'b1, dbl = 1'b0, dfr = 1'b0, mms = 1'b0;
    logic        fm = 1'b0, rs = 1'b0, alt = 1'b0;
    logic [7:0]  cb = 8'h03, ca = 8'h05;
    logic [3:0]  osel = 4'h9;
    wire         hs, vs, hout, vout, gh, gv, clp, pto;
    wire  [15:0] cap;
    wire  [7:0]  pcnt;
    wire  [6:0]  obs = {hout, pto, vout, clp, ~gv, gv, gh};
    int          miscompares = 0, checks_done = 0, cyc = 0;
    // Clock, source model and design
    always #25 CLK_SYS_I = ~CLK_SYS_I;
    vsm_src SRC (.clk_i(CLK_SYS_I), .rst_i(RST_I), .dbl_i(dbl), .hs_o(hs), .vs_o(vs));
    vsm_sync_mod DUT (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .HORIZ_SYNC_IN_I(hs), .VERT_SYNC_IN_I(vs),
        .DOUBLE_FREQ_REMOVAL_I(dfr), .MASK_MODE_SEL_I(mms), .MASK_OFFSET_REG_I(8'h04),
        .FALL_MOD_I(fm), .RESYNC_I(rs), .COMPARE_CONST_B_I(cb), .PULSE_CONST_A_I(ca), .OUTPUT_SEL_I(osel),
        .ALT_ADD_MODE_SEL_I(alt), .RISE_ADD_VALUE_I(16'h001C), .FALL_ADD_VALUE_I(16'h0004),
        .LINE_CONST_A_I(8'h0F), .LINE_CONST_B_I(8'h03), .HORIZ_SYNC_OUT_SEL_O(hout),
        .VERT_SYNC_OUT_SEL_O(vout), .GEN_HORIZ_SYNC_O(gh), .GEN_VERT_SYNC_O(gv), .CLAMP_PULSE_FOUR_O(clp),
        .PULSE_TIMER_OUT_O(pto), .CAPTURE_D_REG_O(cap), .PULSE_COUNT_O(pcnt));
    // Hang guard
    always @(posedge CLK_SYS_I) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            $display("ERROR %0t timeout", $time);
            print_verdict();
        end
    end
    // Comparisons, measurements and reset
    task automatic chk(input int got, exp, tol);
        checks_done++;
        if (got < exp - tol || got > exp + tol) begin
            miscompares++;
            $display("ERROR %0t length %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic chk16(input logic [15:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hi_len(input int k, output int n);
        n = 0;
        while (obs[k] !== 1'b0) @(negedge CLK_SYS_I);
        while (obs[k] !== 1'b1) @(negedge CLK_SYS_I);
        while (obs[k] === 1'b1) begin
            @(negedge CLK_SYS_I);
            n++;
        end
    endtask
    task automatic rises(input int k, len, output int n);
        logic p;
        n = 0;
        p = obs[k];
        repeat (len) begin
            @(negedge CLK_SYS_I);
            if (obs[k] === 1'b1 && p !== 1'b1) n++;
            p = obs[k];
        end
    endtask
    task automatic rst();
        @(posedge CLK_SYS_I) RST_I <= 1'b1;
        repeat (2) @(posedge CLK_SYS_I);
        RST_I <= 1'b0;
    endtask
    // Scenarios
    task automatic t_mask();
        int n;
        logic [15:0] c0;
        @(posedge CLK_SYS_I) dbl <= 1'b1;
        dfr <= 1'b1;
        rst();
        rises(6, 480, n);
        chk(n, 10, 0);
        @(posedge CLK_SYS_I) mms <= 1'b1;
        rst();
        rises(6, 480, n);
        chk(n, 5, 0);
        rises(6, 96, n);
        c0 = cap;
        rises(6, 96, n);
        chk16(cap - c0, 16'h000C);
    endtask
    task automatic t_vert();
        int n;
        for (int m = 0; m < 3; m++) begin
            @(posedge CLK_SYS_I) fm <= (m == 1);
            rs <= (m == 2);
            dbl <= 1'b0;
            dfr <= 1'b0;
            rst();
            hi_len(4, n);
            chk(n, m == 0 ? 192 : m == 1 ? 552 : 264, 6);
        end
    endtask
    task automatic t_ptim();
        int n;
        @(posedge CLK_SYS_I) fm <= 1'b0;
        rst();
        hi_len(5, n);
        chk(n, 2 * 96, 6);
        @(posedge CLK_SYS_I) osel <= 4'h3;
        rst();
        hi_len(5, n);
        chk(n, 960, 6);
    endtask
    task automatic t_gen();
        int n;
        @(posedge CLK_SYS_I) alt <= 1'b1;
        rst();
        hi_len(1, n);
        chk(n, 4 * 8, 1);
        hi_len(2, n);
        chk(n, 28 * 8, 1);
        hi_len(0, n);
        chk(n, 4 * 4, 1);
        hi_len(3, n);
        chk(n, 6, 0);
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst();
        t_mask();
        t_vert();
        t_ptim();
        t_gen();
        print_verdict();
    end
endmodule // testbench
